/* File: core/aagor_pkg.sv */
/*
 * constants for the averaging, gain and offset register bank.
 * assumes a byte-wide register write/read port framed by an active-low chip select.
 */
package aagor_pkg;
    localparam logic [7:0] ADDR_LEAVE_SETUP = 8'h14;
    localparam logic [7:0] ADDR_AVERAGING = 8'h15;
    localparam logic [7:0] ADDR_CH0_OFS_LO = 8'h17;
    localparam logic [7:0] ADDR_CH0_OFS_HI = 8'h18;
    localparam logic [7:0] ADDR_CH1_OFS_LO = 8'h1A;
    localparam logic [7:0] ADDR_CH1_OFS_HI = 8'h1B;
    localparam logic [7:0] ADDR_CH0_GAIN_LO = 8'h1C;
    localparam logic [7:0] ADDR_CH0_GAIN_HI = 8'h1D;
    localparam logic [7:0] ADDR_CH1_GAIN_LO = 8'h1E;
    localparam logic [7:0] ADDR_CH1_GAIN_HI = 8'h1F;
    localparam logic [7:0] ADDR_OUT_MODE = 8'h20;
    localparam int LEAVE_BIT = 0;
    localparam int RESTART_BIT = 7;
    localparam int LEN_MSB = 4;
    localparam int FMT_MSB = 2;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_GAIN_HI = 8'h80;
    localparam logic [4:0] LEN_NONE = 5'h00;
    localparam logic [4:0] LEN_MAX = 5'h10;
    localparam logic [2:0] FMT_AVERAGED = 3'h3;
    localparam int SAMPLE_W = 16;
    localparam int GAIN_SHIFT = 15;
    localparam int ACC_W = 34;
    localparam int AVG_OUT_W = 30;
endpackage

/* File: core/aagor_corrector.sv */
/*
 * per-channel gain and offset correction of one signed sample.
 * assumes sample_valid is a one-cycle pulse from the converter.
 */
`timescale 1ns/100ps
module aagor_corrector
    import aagor_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample in
    input wire logic sample_valid,
    input wire logic signed [aagor_pkg::SAMPLE_W-1:0] sample_in,
    // settings
    input wire logic [15:0] gain_word,
    input wire logic signed [15:0] offset_word,
    // corrected out
    output logic corr_valid,
    output logic signed [aagor_pkg::SAMPLE_W+1:0] corr_out
);
    logic signed [17:0] corr_nxt;
    logic signed [33:0] prod;
    logic signed [18:0] sum;

    // offset added first, then gain of word/0x8000
    always_comb begin
        sum = 19'(sample_in) + 19'(offset_word);
        prod = 34'(sum) * $signed({18'h00000, gain_word});
        corr_nxt = 18'(prod >>> GAIN_SHIFT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            corr_valid <= 1'b0;
            corr_out <= 18'sh00000;
        end else begin
            corr_valid <= sample_valid;
            if (sample_valid) begin
                corr_out <= corr_nxt;
            end
        end
    end
endmodule

/* File: core/aagor_averager.sv */
/*
 * block averaging filter over 2^n corrected samples.
 * assumes the length code is 1..16 while averaging is in use.
 */
`timescale 1ns/100ps
module aagor_averager
    import aagor_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic restart,
    input wire logic [4:0] block_length_code,
    // samples
    input wire logic in_valid,
    input wire logic signed [17:0] in_data,
    // result
    output logic out_valid,
    output logic signed [aagor_pkg::AVG_OUT_W-1:0] out_data
);
    localparam int EXTRA_W = AVG_OUT_W - SAMPLE_W - 2;
    logic signed [ACC_W-1:0] acc_r, acc_nxt, acc_sum;
    // widened before the scale-up so a full-scale 2^16 block cannot wrap
    logic signed [ACC_W+EXTRA_W-1:0] acc_wide;
    logic [16:0] cnt_r, cnt_nxt;
    logic [16:0] last;
    logic done;

    always_comb begin
        last = 17'((18'h00001 << block_length_code) - 18'h00001);
        acc_sum = acc_r + ACC_W'(in_data);
        acc_wide = (ACC_W+EXTRA_W)'(acc_sum) <<< EXTRA_W;
        done = in_valid && (cnt_r == last);
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        if (restart) begin
            acc_nxt = '0;
            cnt_nxt = '0;
        end else if (in_valid) begin
            acc_nxt = done ? '0 : acc_sum;
            cnt_nxt = done ? 17'h00000 : cnt_r + 17'h00001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
            cnt_r <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            out_valid <= done && !restart;
            if (done && !restart) begin
                // divide by 2^n, keeping the extra resolution bits
                out_data <= AVG_OUT_W'(acc_wide >>> block_length_code);
            end
        end
    end
endmodule

/* File: core/aagor_regs.sv */
/*
 * register bank for averaging, gain and offset of a dual-channel converter.
 * assumes the serial port slave decodes frames into byte writes and reads,
 * and that cs_n is the port's chip select, synchronous to clk.
 */
`timescale 1ns/100ps
module aagor_regs
    import aagor_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial port register access
    input wire logic cs_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // converter samples
    input wire logic sample_valid,
    input wire logic signed [15:0] ch0_sample,
    input wire logic signed [15:0] ch1_sample,
    // status and results
    output logic config_mode,
    output logic [2:0] output_format_select,
    output logic ch0_valid,
    output logic [31:0] ch0_word,
    output logic ch1_valid,
    output logic [31:0] ch1_word
);
    import aagor_pkg::*;

    // ******************************
    // reset release
    // ******************************
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ******************************
    // registers
    // ******************************
    logic leave_setup_bit_r, leave_setup_bit_nxt;
    logic filter_restart_bit_r, filter_restart_bit_nxt;
    logic [4:0] block_length_code_r, block_length_code_nxt;
    logic [7:0] regs_r [0:7];
    logic [7:0] regs_nxt [0:7];
    logic [2:0] fmt_nxt;
    logic cfg_nxt;
    logic [7:0] rd_nxt;
    localparam logic [7:0] BYTE_ADDR [0:7] = '{ADDR_CH0_OFS_LO, ADDR_CH0_OFS_HI,
        ADDR_CH1_OFS_LO, ADDR_CH1_OFS_HI, ADDR_CH0_GAIN_LO, ADDR_CH0_GAIN_HI,
        ADDR_CH1_GAIN_LO, ADDR_CH1_GAIN_HI};
    localparam logic [7:0] BYTE_RST [0:7] = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_GAIN_HI, RST_ZERO, RST_GAIN_HI};

    always_comb begin
        leave_setup_bit_nxt = leave_setup_bit_r;
        if (cs_n) begin
            leave_setup_bit_nxt = 1'b0;
        end
        if (wr_en && !cs_n && addr == ADDR_LEAVE_SETUP) begin
            leave_setup_bit_nxt = wr_data[LEAVE_BIT];
        end
        cfg_nxt = config_mode;
        if (wr_en && !cs_n && addr == ADDR_LEAVE_SETUP && wr_data[LEAVE_BIT]) begin
            cfg_nxt = 1'b0;
        end
        // restart bit lives one cycle only
        filter_restart_bit_nxt = 1'b0;
        block_length_code_nxt = block_length_code_r;
        fmt_nxt = output_format_select;
        if (wr_en && !cs_n && addr == ADDR_AVERAGING) begin
            filter_restart_bit_nxt = wr_data[RESTART_BIT];
            block_length_code_nxt = wr_data[LEN_MSB:0];
        end
        if (wr_en && !cs_n && addr == ADDR_OUT_MODE) begin
            fmt_nxt = wr_data[FMT_MSB:0];
        end
    end

    // one byte register per entry, written on address match
    for (genvar i = 0; i < 8; i++) begin : g_byte
        always_comb begin
            regs_nxt[i] = regs_r[i];
            if (wr_en && !cs_n && addr == BYTE_ADDR[i]) begin
                regs_nxt[i] = wr_data;
            end
        end
        always_ff @(posedge clk or negedge rst_n_r) begin
            if (!rst_n_r) begin
                regs_r[i] <= BYTE_RST[i];
            end else begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end

    // ******************************
    // read path
    // ******************************
    always_comb begin
        rd_nxt = rd_data;
        if (rd_en && !cs_n) begin
            if (addr == ADDR_LEAVE_SETUP) begin
                rd_nxt = {7'h00, leave_setup_bit_r};
            end else if (addr == ADDR_AVERAGING) begin
                rd_nxt = {filter_restart_bit_r, 2'h0, block_length_code_r};
            end else if (addr == ADDR_OUT_MODE) begin
                rd_nxt = {5'h00, output_format_select};
            end else begin
                rd_nxt = 8'h00;
                for (int k = 0; k < 8; k++) begin
                    if (addr == BYTE_ADDR[k]) begin
                        rd_nxt = regs_r[k];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            leave_setup_bit_r <= 1'b0;
            filter_restart_bit_r <= 1'b0;
            block_length_code_r <= LEN_NONE;
            output_format_select <= 3'h0;
            config_mode <= 1'b1;
            rd_data <= RST_ZERO;
        end else begin
            leave_setup_bit_r <= leave_setup_bit_nxt;
            filter_restart_bit_r <= filter_restart_bit_nxt;
            block_length_code_r <= block_length_code_nxt;
            output_format_select <= fmt_nxt;
            config_mode <= cfg_nxt;
            rd_data <= rd_nxt;
        end
    end

    // ******************************
    // datapath per channel
    // ******************************
    logic c_valid [0:1];
    logic signed [17:0] c_data [0:1];
    logic a_valid [0:1];
    logic signed [29:0] a_data [0:1];
    logic [31:0] word_nxt [0:1];
    logic valid_nxt [0:1];
    logic [31:0] word_r [0:1];
    logic valid_r [0:1];
    logic averaging;
    assign averaging = output_format_select == FMT_AVERAGED;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        aagor_corrector u_corr (
            .clk(clk),
            .rst_n(rst_n_r),
            .sample_valid(sample_valid),
            .sample_in(c == 0 ? ch0_sample : ch1_sample),
            .gain_word({regs_r[5 + 2*c], regs_r[4 + 2*c]}),
            .offset_word({regs_r[1 + 2*c], regs_r[2*c]}),
            .corr_valid(c_valid[c]),
            .corr_out(c_data[c])
        );
        aagor_averager u_avg (
            .clk(clk),
            .rst_n(rst_n_r),
            .restart(filter_restart_bit_r),
            .block_length_code(block_length_code_r),
            .in_valid(c_valid[c] && averaging),
            .in_data(c_data[c]),
            .out_valid(a_valid[c]),
            .out_data(a_data[c])
        );
        always_comb begin
            valid_nxt[c] = averaging ? a_valid[c] : c_valid[c];
            word_nxt[c] = word_r[c];
            if (averaging && a_valid[c]) begin
                // overrange when the top two bits of the 30-bit result differ, each channel on its own block
                word_nxt[c] = {a_data[c], a_data[c][29] ^ a_data[c][28], 1'b1};
            end else if (!averaging && c_valid[c]) begin
                word_nxt[c] = {16'h0000, c_data[c][15:0]};
            end
        end
        always_ff @(posedge clk or negedge rst_n_r) begin
            if (!rst_n_r) begin
                word_r[c] <= 32'h00000000;
                valid_r[c] <= 1'b0;
            end else begin
                word_r[c] <= word_nxt[c];
                valid_r[c] <= valid_nxt[c];
            end
        end
    end

    assign ch0_word = word_r[0];
    assign ch1_word = word_r[1];
    assign ch0_valid = valid_r[0];
    assign ch1_valid = valid_r[1];

    // ******************************
    // checks
    // ******************************
    a_leave_clears: assert property (@(posedge clk) disable iff (!rst_n_r)
        cs_n |=> !leave_setup_bit_r) else $error("leave bit not cleared");
    a_leave_exit: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_LEAVE_SETUP && wr_data[LEAVE_BIT] |=> !config_mode)
        else $error("config mode not left");
    a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n_r)
        filter_restart_bit_r && !(wr_en && addr == ADDR_AVERAGING) |=> !filter_restart_bit_r)
        else $error("restart bit stuck");
    a_len_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_AVERAGING |=> block_length_code_r == $past(wr_data[4:0]))
        else $error("length code not stored");
    a_ofs1_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH1_OFS_HI |=> regs_r[3] == $past(wr_data))
        else $error("ch1 offset high not stored");
    a_gain0_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH0_GAIN_LO |=> regs_r[4] == $past(wr_data))
        else $error("ch0 gain low not stored");
    a_gain1_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH1_GAIN_LO |=> regs_r[6] == $past(wr_data))
        else $error("ch1 gain low not stored");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n_r)
        rd_en && !cs_n && addr == ADDR_AVERAGING |=> rd_data[6:5] == 2'h0)
        else $error("reserved bits not zero");
    a_corr_timing: assert property (@(posedge clk) disable iff (!rst_n_r)
        sample_valid && !averaging ##1 !averaging |=> ch0_valid)
        else $error("corrected sample late");
    // every byte lands in its own register one cycle after the strobe
    a_ofs0_lo_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH0_OFS_LO |=> regs_r[0] == $past(wr_data))
        else $error("ch0 offset low not stored");
    a_ofs0_hi_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH0_OFS_HI |=> regs_r[1] == $past(wr_data))
        else $error("ch0 offset high not stored");
    a_ofs1_lo_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH1_OFS_LO |=> regs_r[2] == $past(wr_data))
        else $error("ch1 offset low not stored");
    a_gain0_hi_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH0_GAIN_HI |=> regs_r[5] == $past(wr_data))
        else $error("ch0 gain high not stored");
    a_gain1_hi_store: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_CH1_GAIN_HI |=> regs_r[7] == $past(wr_data))
        else $error("ch1 gain high not stored");
    // reset values seen at the first edge out of reset
    a_ofs_reset: assert property (@(posedge clk) disable iff (!rst_n_r)
        $rose(rst_n_r) |-> regs_r[0] == RST_ZERO && regs_r[1] == RST_ZERO)
        else $error("ch0 offset reset wrong");
    a_gain_reset: assert property (@(posedge clk) disable iff (!rst_n_r)
        $rose(rst_n_r) |-> regs_r[4] == RST_ZERO && regs_r[5] == RST_GAIN_HI)
        else $error("ch0 gain reset wrong");
    a_cfg_sticky: assert property (@(posedge clk) disable iff (!rst_n_r)
        !config_mode |=> !config_mode)
        else $error("config mode came back");
    a_leave_set: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_LEAVE_SETUP
        |=> leave_setup_bit_r == $past(wr_data[LEAVE_BIT]))
        else $error("leave bit not written");
    a_leave_hold: assert property (@(posedge clk) disable iff (!rst_n_r)
        leave_setup_bit_r && !cs_n && !(wr_en && addr == ADDR_LEAVE_SETUP)
        |=> leave_setup_bit_r)
        else $error("leave bit lost inside frame");
    a_restart_set: assert property (@(posedge clk) disable iff (!rst_n_r)
        wr_en && !cs_n && addr == ADDR_AVERAGING && wr_data[RESTART_BIT]
        |=> filter_restart_bit_r)
        else $error("restart bit not set");
    a_restart_drop: assert property (@(posedge clk) disable iff (!rst_n_r)
        filter_restart_bit_r |=> !a_valid[0] && !a_valid[1])
        else $error("result during filter restart");
    a_rsvd_leave: assert property (@(posedge clk) disable iff (!rst_n_r)
        rd_en && !cs_n && addr == ADDR_LEAVE_SETUP |=> rd_data[7:1] == 7'h00)
        else $error("leave reserved bits not zero");
    a_avg_word: assert property (@(posedge clk) disable iff (!rst_n_r)
        averaging && a_valid[0] |=> ch0_word[0] && ch0_word[31:2] == $past(a_data[0]))
        else $error("averaged word layout wrong");
    a_chan_pair: assert property (@(posedge clk) disable iff (!rst_n_r)
        ch0_valid |-> ch1_valid)
        else $error("channel results not paired");
endmodule

/* File: bench/aagor_host_model.sv */
/* host model on the chip-select framed register port.
   assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module aagor_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic cs_n,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wr_data
);
    import aagor_pkg::*;
    logic [4:0] len_code;
    initial begin
        cs_n = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        len_code = 5'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] dd;
        dd = d;
        if (w && a == ADDR_AVERAGING && dd[4:0] > LEN_MAX) dd[4:0] = LEN_MAX;
        if (w && a == ADDR_AVERAGING) len_code = dd[4:0];
        if (w && a == ADDR_OUT_MODE && dd[2:0] == FMT_AVERAGED && len_code == LEN_NONE) begin
            dd[2:0] = 3'h0;
        end
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        wr_en = w;
        rd_en = !w;
        addr = a;
        wr_data = dd;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        // released bus shows a changing pattern, not the old value
        addr = ~a;
        wr_data = ~dd;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 8'h00);
    endtask
    task automatic end_frame;
        @(posedge clk);
        #1;
        cs_n = 1'b1;
    endtask
endmodule

/* File: bench/tb_aagor_regs.sv */
/* self-checking bench for the register bank.
   assumes aagor_host_model drives the register port. */
`timescale 1ns/100ps
module tb_aagor_regs;
    import aagor_pkg::*;
    logic clk, reset_n, cs_n, wr_en, rd_en, sample_valid, config_mode, ch0_valid, ch1_valid;
    logic [7:0] addr, wr_data, rd_data, d;
    logic signed [15:0] ch0_sample, ch1_sample;
    logic [2:0] output_format_select;
    logic [31:0] ch0_word, ch1_word;
    logic [7:0] rq[$];
    logic [31:0] q0[$], q1[$];
    logic rd_pend;
    int n_mismatch, n_tests;
    logic signed [15:0] ofs[2];
    logic [15:0] gn[2];
    aagor_regs uut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .sample_valid(sample_valid),
        .ch0_sample(ch0_sample), .ch1_sample(ch1_sample), .config_mode(config_mode),
        .output_format_select(output_format_select), .ch0_valid(ch0_valid),
        .ch0_word(ch0_word), .ch1_valid(ch1_valid), .ch1_word(ch1_word));
    aagor_host_model host (.clk(clk), .cs_n(cs_n), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****************
    // compare helpers
    // ****************
    task automatic miss(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        miss({24'h0, e}, {24'h0, g});
    endtask
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        miss(e, g);
    endtask
    task automatic cmp_lvl(input logic e, input logic g);
        miss({31'h0, e}, {31'h0, g});
    endtask
    function automatic logic signed [17:0] corr(input logic signed [15:0] s,
        input logic signed [15:0] o, input logic [15:0] g);
        longint p;
        p = (longint'(s) + longint'(o)) * longint'(g);
        p = p >>> 15;
        return p[17:0];
    endfunction
    always @(posedge clk) begin
        if (rd_pend) cmp_byte(rq.size() ? rq.pop_front() : 'x, rd_data);
        rd_pend = rd_en & ~cs_n;
        if (ch0_valid) cmp_word(q0.size() ? q0.pop_front() : 'x, ch0_word);
        if (ch1_valid) cmp_word(q1.size() ? q1.pop_front() : 'x, ch1_word);
    end
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        host.rd(a);
    endtask
    task automatic setc(input int ch, input logic [15:0] o, input logic [15:0] g);
        logic [7:0] b;
        b = ch ? ADDR_CH1_OFS_LO : ADDR_CH0_OFS_LO;
        host.wr(b, o[7:0]);
        host.wr(b + 8'h01, o[15:8]);
        b = ch ? ADDR_CH1_GAIN_LO : ADDR_CH0_GAIN_LO;
        host.wr(b, g[7:0]);
        host.wr(b + 8'h01, g[15:8]);
        ofs[ch] = o;
        gn[ch] = g;
    endtask
    task automatic smp(input logic [15:0] s0, input logic [15:0] s1, input logic push);
        logic [17:0] c0, c1;
        c0 = corr(s0, ofs[0], gn[0]);
        c1 = corr(s1, ofs[1], gn[1]);
        if (push) q0.push_back({16'h0, c0[15:0]});
        if (push) q1.push_back({16'h0, c1[15:0]});
        @(posedge clk);
        #1;
        sample_valid = 1'b1;
        ch0_sample = s0;
        ch1_sample = s1;
        @(posedge clk);
        #1;
        sample_valid = 1'b0;
        ch0_sample = ~s0;
        ch1_sample = ~s1;
    endtask
    task automatic avg_run(input int n, input int lo);
        logic [15:0] a0[$], a1[$];
        longint s0, s1;
        logic [29:0] w0, w1;
        s0 = 0;
        s1 = 0;
        host.wr(ADDR_AVERAGING, 8'h80 | 8'(n));
        for (int i = 0; i < (1 << n); i++) begin
            a0.push_back(16'(lo + $urandom_range(999)));
            a1.push_back(16'(lo + $urandom_range(999)));
            s0 += longint'(corr(a0[i], ofs[0], gn[0]));
            s1 += longint'(corr(a1[i], ofs[1], gn[1]));
        end
        w0 = 30'((s0 <<< 12) >>> n);
        w1 = 30'((s1 <<< 12) >>> n);
        // overrange flags a result whose top two bits differ
        q0.push_back({w0, w0[29] ^ w0[28], 1'b1});
        q1.push_back({w1, w1[29] ^ w1[28], 1'b1});
        for (int i = 0; i < (1 << n); i++) smp(a0[i], a1[i], 1'b0);
        repeat (6) @(posedge clk);
    endtask
    task end_of_test;
        if (rq.size() || q0.size() || q1.size()) n_mismatch++;
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        void'($urandom(26));
        reset_n = 1'b0;
        sample_valid = 1'b0;
        ch0_sample = 16'h0000;
        ch1_sample = 16'h0000;
        rd_pend = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        ofs = '{16'h0000, 16'h0000};
        gn = '{16'h8000, 16'h8000};
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge clk);
        cmp_lvl(1'b1, config_mode);
        for (int a = 8'h13; a <= 8'h21; a++) begin
            d = (a == ADDR_CH0_GAIN_HI || a == ADDR_CH1_GAIN_HI) ? RST_GAIN_HI : RST_ZERO;
            rd_chk(8'(a), d);
        end
        repeat (4) smp(16'($urandom), 16'($urandom), 1'b1);
        // unmapped holes must swallow writes
        for (int a = 8'h16; a <= 8'h1F; a++) begin
            d = 8'($urandom);
            host.wr(8'(a), d);
            rd_chk(8'(a), (a == 8'h16 || a == 8'h19) ? 8'h00 : d);
        end
        host.wr(ADDR_AVERAGING, 8'hEA);
        rd_chk(ADDR_AVERAGING, 8'h0A);
        for (int k = 0; k < 3; k++) begin
            setc(0, 16'($urandom), k == 0 ? 16'hFFFF : 16'($urandom));
            setc(1, 16'($urandom), 16'($urandom));
            repeat (4) smp(16'($urandom), 16'($urandom), 1'b1);
        end
        setc(0, 16'h0010, 16'h8000);
        setc(1, 16'h0000, 16'h4000);
        host.wr(ADDR_AVERAGING, 8'h82);
        host.wr(ADDR_OUT_MODE, {5'h00, FMT_AVERAGED});
        rd_chk(ADDR_OUT_MODE, 8'h03);
        cmp_byte(8'h03, {5'h00, output_format_select});
        // a partial block that the restart must throw away
        repeat (3) smp(16'h0100, 16'h0100, 1'b0);
        avg_run(2, 0);
        avg_run(1, 0);
        avg_run(3, 0);
        // near full scale: overrange on channel 0, negative sums on channel 1
        setc(0, 16'h7FFF, 16'hFFFF);
        setc(1, 16'h8000, 16'h8000);
        avg_run(1, 16'h7000);
        host.wr(ADDR_LEAVE_SETUP, 8'hFE);
        rd_chk(ADDR_LEAVE_SETUP, 8'h00);
        cmp_lvl(1'b1, config_mode);
        host.wr(ADDR_LEAVE_SETUP, 8'h01);
        rd_chk(ADDR_LEAVE_SETUP, 8'h01);
        cmp_lvl(1'b0, config_mode);
        host.end_frame();
        repeat (2) @(posedge clk);
        rd_chk(ADDR_LEAVE_SETUP, 8'h00);
        repeat (10) @(posedge clk);
        end_of_test;
    end
endmodule
